// [design/acs_pkg.sv]
// ----------------------------------------------------------------------
// Shared constants and carriers for the channel sequencer config bank
// ----------------------------------------------------------------------
package acs_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NCH = 4; // Channel registers
  localparam int NSU = 4; // Setups
  localparam int DW = 24; // Widest register

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_SERIAL_INTERFACE_MODE = 8'h02;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_SETUP_BASE = 8'h20;
  localparam logic [7:0] ADDR_FILT_BASE = 8'h28;
  localparam logic [7:0] ADDR_OFFS_BASE = 8'h30;
  localparam logic [7:0] ADDR_GAIN_BASE = 8'h38;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_RST = 16'h8000;
  localparam logic [15:0] SERIAL_INTERFACE_MODE_RST = 16'h0000;
  localparam logic [15:0] CH0_RST = 16'h8001;
  localparam logic [15:0] CHN_RST = 16'h0001;
  localparam logic [15:0] SETUP_RST = 16'h1020;
  localparam logic [15:0] FILT_RST = 16'h0000;
  localparam logic [23:0] OFFS_RST = 24'h800000;
  localparam logic [23:0] GAIN_RST = 24'h500000;

  // ----------------------------------------------------------------------
  // Writable bits; reserved bits read as zero
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_MASK = 16'ha77c;
  localparam logic [15:0] SERIAL_INTERFACE_MODE_MASK = 16'h1ded;
  localparam logic [15:0] CH_MASK = 16'hf3ff;
  localparam logic [15:0] SETUP_MASK = 16'h1030;
  localparam logic [15:0] FILT_MASK = 16'h8f7f;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CH_EN_BIT = 15;
  localparam int CH_SETUP_LSB = 12;
  localparam int CH_POS_LSB = 5;
  localparam int CH_NEG_LSB = 0;
  localparam int IF_CONTINUOUS_READ_ENABLE_BIT = 7;
  localparam int IF_STAT_BIT = 6;
  localparam int IF_CRC_LSB = 2;
  localparam int IF_WL_BIT = 0;
  localparam int MODE_REFEN_BIT = 15;
  localparam int MODE_SING_BIT = 13;
  localparam int MODE_DELAY_LSB = 8;
  localparam int MODE_CONV_LSB = 4;
  localparam int MODE_CLK_LSB = 2;
  localparam int SU_BIPOLAR_BIT = 12;
  localparam int SU_REF_LSB = 4;
  localparam logic [2:0] MODE_CONT = 3'h0; // Continuous conversion

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } acs_bus_s;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [4:0] pinPos;
    logic [4:0] pinNeg;
    logic [1:0] setup;
  } acs_route_s;

  typedef struct packed {
    logic bipolar;
    logic [1:0] refSel;
    logic [15:0] filter;
    logic [23:0] offset;
    logic [23:0] gain;
  } acs_setup_s;

  typedef struct packed {
    logic shortWord;
    logic [1:0] crcMode;
    logic statusAppend;
    logic continuous_read_enable;
  } acs_iface_s;

endpackage

// [design/acs_chan_seq.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Channel sequencer: walks enabled channels in ascending order
// ----------------------------------------------------------------------
module acs_chan_seq (
  input logic clk,
  input logic rst,
  input logic [3:0] en,
  input logic run,
  input logic convDone,
  output logic [1:0] cur_r,
  output logic active_r
);
  import acs_pkg::*;

  logic [1:0] curNxt; // Next channel index
  logic activeNxt; // Next running flag

  // Lowest enabled channel strictly after from, wrapping; from if none else
  function automatic logic [1:0] nextEnabled(input logic [3:0] e, input logic [1:0] from);
    logic [1:0] pick;
    logic [1:0] idx;
    pick = from;
    for (int i = 4; i >= 1; i--) begin
      idx = from + i[1:0];
      if (e[idx]) begin
        pick = idx;
      end
    end
    return pick;
  endfunction

  // Next state: hold on a channel until its result is out
  always_comb begin
    curNxt = cur_r;
    activeNxt = run && (|en);
    if (!activeNxt) begin
      // Idle: park on the lowest enabled channel
      curNxt = nextEnabled(en, 2'h3);
    end else if (!active_r) begin
      // Start of a run always begins at the lowest one
      curNxt = nextEnabled(en, 2'h3); // see RQ3
    end else if (convDone) begin
      // Disabled channels are passed over in the search
      curNxt = nextEnabled(en, cur_r); // see RQ3 see RQ9 see RQ12
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_r <= 2'h0;
      active_r <= 1'b0;
    end else begin
      cur_r <= curNxt;
      active_r <= activeNxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  hold_until_done_a: assert property (active_r && run && (|en) && !convDone |=> // see RQ12
    cur_r == $past(cur_r)) else $error("channel moved without a finished result");
  advance_next_a: assert property (active_r && run && (|en) && convDone |=> // see RQ3
    cur_r == $past(nextEnabled(en, cur_r))) else $error("wrong next channel");
  skip_disabled_a: assert property (active_r && run && (|en) && convDone // see RQ9
    ##1 $stable(en) |-> en[cur_r]) else $error("sequencer landed on a disabled channel");
  auto_start_a: assert property (run && (|en) |=> active_r) // see RQ4
    else $error("sequencer did not start");

endmodule // acs_chan_seq

// [design/acs_config_bank.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// RQ1 - Interface mode holds word, checksum, status, continuous-read
// RQ2 - Channel register top bit enables that channel
// RQ3 - Visit enabled channels ascending, then wrap
// RQ4 - Up to four channels, sequenced automatically
// RQ5 - Any of five pins as either input
// RQ6 - Any pin may be shared negative input
// RQ7 - Channels pick own or shared setup
// RQ8 - Software may leave gain and offset unprogrammed
// RQ9 - Disabled channels are skipped
// RQ10 - Reset: channel 0 on, pins 0/1, setup 0
// RQ11 - Setup has config, filter, offset, gain registers
// RQ12 - Advance only after current result completes
module acs_config_bank (
  input logic clk,
  input logic rst,
  input acs_pkg::acs_bus_s bus,
  output logic [23:0] rdData_r,
  input logic convDone,
  output acs_pkg::acs_route_s route_r,
  output acs_pkg::acs_setup_s setupSel_r,
  output acs_pkg::acs_iface_s iface,
  output logic refEnable,
  output logic singleCycle,
  output logic [2:0] delaySel,
  output logic [2:0] convMode,
  output logic [1:0] clockSel
);
  import acs_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] modeReg_r; // Converter mode control
  logic [15:0] modeReg_nxt;
  logic [15:0] ifReg_r; // Serial interface mode
  logic [15:0] ifReg_nxt;
  logic [15:0] chanReg_r [NCH]; // Channel routing and enable
  logic [15:0] chanReg_nxt [NCH];
  logic [15:0] setupReg_r [NSU]; // Coding and reference per setup
  logic [15:0] setupReg_nxt [NSU];
  logic [15:0] filtReg_r [NSU]; // Filter choice per setup
  logic [15:0] filtReg_nxt [NSU];
  logic [23:0] offsReg_r [NSU]; // Offset coefficient per setup
  logic [23:0] offsReg_nxt [NSU];
  logic [23:0] gainReg_r [NSU]; // Gain coefficient per setup
  logic [23:0] gainReg_nxt [NSU];

  // ----------------------------------------------------------------------
  // Sequencing and output staging
  // ----------------------------------------------------------------------
  logic [3:0] chanEn; // Enable bit of every channel
  logic [1:0] seqCur; // Channel the sequencer points at
  logic seqActive; // Sequencer is running
  logic seqRun; // Converter mode allows sequencing
  logic [1:0] curSetup; // Setup of the current channel
  logic [23:0] rdData_nxt;
  acs_route_s route_nxt;
  acs_setup_s setupSel_nxt;

  // True when the address falls in the four-entry bank at base
  function automatic logic inBank(input logic [7:0] a, input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction

  // ----------------------------------------------------------------------
  // Channel enables
  // ----------------------------------------------------------------------
  // Each channel's top bit is its enable
  for (genvar c = 0; c < NCH; c++) begin : g_en
    assign chanEn[c] = chanReg_r[c][CH_EN_BIT]; // see RQ2
  end

  // Sequencing runs in continuous conversion only; any other mode stops
  // the sequencer and parks it on the lowest enabled channel
  assign seqRun = modeReg_r[MODE_CONV_LSB +: 3] == MODE_CONT;

  // Setup chosen by the channel now in use; only two bits pick one of four
  assign curSetup = chanReg_r[seqCur][CH_SETUP_LSB +: 2]; // see RQ7

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  acs_chan_seq u_seq (
    .clk(clk),
    .rst(rst),
    .en(chanEn),
    .run(seqRun),
    .convDone(convDone),
    .cur_r(seqCur),
    .active_r(seqActive)
  );

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Reserved bits are masked on the way in so they always read as zero
  always_comb begin
    modeReg_nxt = modeReg_r;
    ifReg_nxt = ifReg_r;
    chanReg_nxt = chanReg_r;
    setupReg_nxt = setupReg_r;
    filtReg_nxt = filtReg_r;
    offsReg_nxt = offsReg_r;
    gainReg_nxt = gainReg_r;
    if (bus.wr) begin
      if (bus.addr == ADDR_MODE) begin
        modeReg_nxt = bus.wdata[15:0] & MODE_MASK;
      end
      if (bus.addr == ADDR_SERIAL_INTERFACE_MODE) begin
        // Word length, checksum, status append, continuous read
        ifReg_nxt = bus.wdata[15:0] & SERIAL_INTERFACE_MODE_MASK; // see RQ1
      end
      if (inBank(bus.addr, ADDR_CH_BASE)) begin
        // Both pin fields take any code, so any pin can be the
        // common negative of several channels
        chanReg_nxt[bus.addr[1:0]] = bus.wdata[15:0] & CH_MASK; // see RQ5 see RQ6
      end
      if (inBank(bus.addr, ADDR_SETUP_BASE)) begin
        setupReg_nxt[bus.addr[1:0]] = bus.wdata[15:0] & SETUP_MASK; // see RQ11
      end
      if (inBank(bus.addr, ADDR_FILT_BASE)) begin
        filtReg_nxt[bus.addr[1:0]] = bus.wdata[15:0] & FILT_MASK; // see RQ11
      end
      // Correction words keep their reset values until software writes
      // them, which it is free never to do
      if (inBank(bus.addr, ADDR_OFFS_BASE)) begin
        offsReg_nxt[bus.addr[1:0]] = bus.wdata; // see RQ11
      end
      if (inBank(bus.addr, ADDR_GAIN_BASE)) begin
        gainReg_nxt[bus.addr[1:0]] = bus.wdata; // see RQ11
      end
    end
  end

  // Register file flops; reset values are the power-on defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeReg_r <= MODE_RST;
      ifReg_r <= SERIAL_INTERFACE_MODE_RST;
      for (int i = 0; i < NCH; i++) begin
        // Channel 0 comes up live on pins 0 and 1 with setup 0
        chanReg_r[i] <= (i == 0) ? CH0_RST : CHN_RST; // see RQ10
      end
      for (int i = 0; i < NSU; i++) begin
        setupReg_r[i] <= SETUP_RST;
        filtReg_r[i] <= FILT_RST;
        offsReg_r[i] <= OFFS_RST;
        gainReg_r[i] <= GAIN_RST;
      end
    end else begin
      modeReg_r <= modeReg_nxt;
      ifReg_r <= ifReg_nxt;
      chanReg_r <= chanReg_nxt;
      setupReg_r <= setupReg_nxt;
      filtReg_r <= filtReg_nxt;
      offsReg_r <= offsReg_nxt;
      gainReg_r <= gainReg_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  // Data stands for exactly the cycle after the strobe; zero otherwise,
  // and zero for unmapped addresses
  always_comb begin
    rdData_nxt = '0;
    if (bus.rd) begin
      if (bus.addr == ADDR_STATUS) begin
        // Enables, running flag and current channel
        rdData_nxt = {16'h0000, chanEn, 1'b0, seqActive, seqCur};
      end else if (bus.addr == ADDR_MODE) begin
        rdData_nxt = {8'h00, modeReg_r};
      end else if (bus.addr == ADDR_SERIAL_INTERFACE_MODE) begin
        rdData_nxt = {8'h00, ifReg_r};
      end else if (inBank(bus.addr, ADDR_CH_BASE)) begin
        rdData_nxt = {8'h00, chanReg_r[bus.addr[1:0]]};
      end else if (inBank(bus.addr, ADDR_SETUP_BASE)) begin
        rdData_nxt = {8'h00, setupReg_r[bus.addr[1:0]]};
      end else if (inBank(bus.addr, ADDR_FILT_BASE)) begin
        rdData_nxt = {8'h00, filtReg_r[bus.addr[1:0]]};
      end else if (inBank(bus.addr, ADDR_OFFS_BASE)) begin
        rdData_nxt = offsReg_r[bus.addr[1:0]];
      end else if (inBank(bus.addr, ADDR_GAIN_BASE)) begin
        rdData_nxt = gainReg_r[bus.addr[1:0]];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Route and setup towards the converter
  // ----------------------------------------------------------------------
  // Staged one cycle so the outputs come from flops; the converter sees
  // a channel change one clock after the sequencer moves
  always_comb begin
    route_nxt.valid = seqActive && chanEn[seqCur]; // see RQ2 see RQ9
    route_nxt.chan = seqCur; // see RQ3 see RQ4
    route_nxt.pinPos = chanReg_r[seqCur][CH_POS_LSB +: 5]; // see RQ5
    route_nxt.pinNeg = chanReg_r[seqCur][CH_NEG_LSB +: 5]; // see RQ6
    route_nxt.setup = curSetup;
    // Every channel on the same setup shares these settings
    setupSel_nxt.bipolar = setupReg_r[curSetup][SU_BIPOLAR_BIT]; // see RQ7
    setupSel_nxt.refSel = setupReg_r[curSetup][SU_REF_LSB +: 2];
    setupSel_nxt.filter = filtReg_r[curSetup];
    setupSel_nxt.offset = offsReg_r[curSetup]; // see RQ8
    setupSel_nxt.gain = gainReg_r[curSetup]; // see RQ8
  end

  // Output staging flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= '0;
      route_r <= '0;
      setupSel_r <= '0;
    end else begin
      rdData_r <= rdData_nxt;
      route_r <= route_nxt;
      setupSel_r <= setupSel_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Mode fields, taken straight from their register flops
  // ----------------------------------------------------------------------
  assign iface.shortWord = ifReg_r[IF_WL_BIT]; // see RQ1
  assign iface.crcMode = ifReg_r[IF_CRC_LSB +: 2];
  assign iface.statusAppend = ifReg_r[IF_STAT_BIT];
  assign iface.continuous_read_enable = ifReg_r[IF_CONTINUOUS_READ_ENABLE_BIT];
  assign refEnable = modeReg_r[MODE_REFEN_BIT];
  assign singleCycle = modeReg_r[MODE_SING_BIT];
  assign delaySel = modeReg_r[MODE_DELAY_LSB +: 3];
  assign convMode = modeReg_r[MODE_CONV_LSB +: 3];
  assign clockSel = modeReg_r[MODE_CLK_LSB +: 2];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // All checks run on the system clock and sleep through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  serial_interface_mode_fields_a: assert property (bus.wr && bus.addr == ADDR_SERIAL_INTERFACE_MODE |=> // see RQ1
    iface.continuous_read_enable == $past(bus.wdata[IF_CONTINUOUS_READ_ENABLE_BIT]) &&
    iface.shortWord == $past(bus.wdata[IF_WL_BIT]) &&
    iface.crcMode == $past(bus.wdata[IF_CRC_LSB +: 2]))
    else $error("interface mode fields not taken");

  // A live, enabled channel must show up on the route a clock later
  enable_route_a: assert property (seqActive && chanEn[seqCur] |=> // see RQ2
    route_r.valid && route_r.chan == $past(seqCur))
    else $error("enabled channel not routed");

  // A parked disabled channel is never offered to the converter
  disabled_quiet_a: assert property (!chanEn[seqCur] |=> !route_r.valid) // see RQ9
    else $error("disabled channel routed");

  // Pin codes are stored untouched, whatever pin they name
  pin_fields_a: assert property (bus.wr && inBank(bus.addr, ADDR_CH_BASE) |=> // see RQ5
    chanReg_r[$past(bus.addr[1:0])][9:0] == $past(bus.wdata[9:0]))
    else $error("pin selection not stored");

  setup_follow_a: assert property (seqActive |=> // see RQ7
    setupSel_r.offset == $past(offsReg_r[curSetup]) &&
    setupSel_r.filter == $past(filtReg_r[curSetup]))
    else $error("setup does not follow the channel");

  // Defaults checked at the first edge after release, before any write
  reset_default_a: assert property ($fell(rst) |-> // see RQ10
    chanReg_r[0] == CH0_RST && offsReg_r[0] == OFFS_RST)
    else $error("reset defaults wrong");

  // Full 24-bit coefficient comes back on a read
  gain_readback_a: assert property (bus.rd && inBank(bus.addr, ADDR_GAIN_BASE) |=> // see RQ11
    rdData_r == $past(gainReg_r[bus.addr[1:0]]))
    else $error("gain readback wrong");

  // Read data must not linger, or a slow master would see stale words
  read_only_once_a: assert property (!bus.rd |=> rdData_r == '0)
    else $error("read data outside its cycle");

  // Pins of the channel in use reach the converter a clock later
  pin_route_a: assert property (seqActive |=> // see RQ5
    route_r.pinPos == $past(chanReg_r[seqCur][CH_POS_LSB +: 5]) &&
    route_r.pinNeg == $past(chanReg_r[seqCur][CH_NEG_LSB +: 5]))
    else $error("pin pair not routed");

  // Setup field of the channel picks the shared settings
  setup_select_a: assert property (seqActive |=> // see RQ7
    route_r.setup == $past(chanReg_r[seqCur][CH_SETUP_LSB +: 2]) &&
    setupSel_r.gain == $past(gainReg_r[chanReg_r[seqCur][CH_SETUP_LSB +: 2]]))
    else $error("setup selection wrong");

  // Correction words land whole; they are never masked
  offset_store_a: assert property (bus.wr && inBank(bus.addr, ADDR_OFFS_BASE) |=> // see RQ11
    offsReg_r[$past(bus.addr[1:0])] == $past(bus.wdata))
    else $error("offset word not stored");

  // Leaving continuous mode takes the route off within two clocks
  stop_idle_a: assert property (!seqRun |-> ##2 !route_r.valid) // see RQ4
    else $error("route live outside continuous mode");

endmodule // acs_config_bank

// [tb/acs_config_bank_tb.sv]
`timescale 1ns/1ps
module acs_config_bank_tb;
  import acs_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and expectation state
  // ----------------------------------------------------------------------
  logic clk; // 40 MHz system clock
  logic rst; // Async reset, active high
  logic convDone; // Converter result strobe
  acs_bus_s bus; // Register bus request
  logic [23:0] rdData_r;
  acs_route_s route_r;
  acs_setup_s setupSel_r;
  acs_iface_s iface;
  logic refEnable;
  logic singleCycle;
  logic [2:0] delaySel;
  logic [2:0] convMode;
  logic [1:0] clockSel;
  int num_errors; // Mismatches seen
  int comparisons; // Comparisons made
  logic [31:0] rngState; // Xorshift state, fixed start for repeatable runs
  logic [15:0] chModel [NCH]; // Expected channel registers
  logic [15:0] suModel [NSU]; // Expected setup configuration
  logic [15:0] filtModel [NSU]; // Expected filter configuration
  logic [23:0] offModel [NSU];
  logic [23:0] gainModel [NSU];
  logic [1:0] curChan; // Channel the sequencer should be on
  logic [3:0] enMask; // Enabled channels

  acs_config_bank u_acs_config_bank (
    .clk(clk), .rst(rst), .bus(bus), .rdData_r(rdData_r), .convDone(convDone),
    .route_r(route_r), .setupSel_r(setupSel_r), .iface(iface), .refEnable(refEnable),
    .singleCycle(singleCycle), .delaySel(delaySel), .convMode(convMode), .clockSel(clockSel)
  );

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run is about a thousand cycles; this span only trips on a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction

  // Next enabled channel above the current one, wrapping to the lowest
  function automatic logic [1:0] nextEn(input logic [1:0] cur, input logic [3:0] en);
    logic [1:0] c;
    for (int i = 1; i <= 4; i++) begin
      c = cur + 2'(i);
      if (en[c]) return c;
    end
    return cur;
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One-cycle write strobe; the strobe drops at the edge that takes it
  task automatic busWrite(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic readCheck(input string what, input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(what, rdData_r, exp);
  endtask

  task automatic checkRoute();
    logic [1:0] s;
    s = chModel[curChan][13:12];
    check("route valid", 24'(route_r.valid), 24'h1);
    check("route chan", 24'(route_r.chan), 24'(curChan));
    check("route pos", 24'(route_r.pinPos), 24'(chModel[curChan][9:5]));
    check("route neg", 24'(route_r.pinNeg), 24'(chModel[curChan][4:0]));
    check("route setup", 24'(route_r.setup), 24'(s));
    check("bipolar", 24'(setupSel_r.bipolar), 24'(suModel[s][SU_BIPOLAR_BIT]));
    check("refSel", 24'(setupSel_r.refSel), 24'(suModel[s][SU_REF_LSB +: 2]));
    check("filter", 24'(setupSel_r.filter), 24'(filtModel[s]));
    check("offset", setupSel_r.offset, offModel[s]);
    check("gain", setupSel_r.gain, gainModel[s]);
  endtask

  // Pulse convDone for n back-to-back cycles, then hold still and recheck
  task automatic advance(input int n);
    @(posedge clk);
    convDone <= 1'b1;
    repeat (n) @(posedge clk);
    convDone <= 1'b0;
    repeat (n) curChan = nextEn(curChan, enMask);
    @(posedge clk);
    #1 checkRoute();
    repeat (4) @(posedge clk);
    #1 check("held chan", 24'(route_r.chan), 24'(curChan));
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic [4:0] common;
    rst = 1'b1;
    convDone = 1'b0;
    bus = '0;
    rngState = 32'd60431;
    num_errors = 0;
    comparisons = 0;
    for (int i = 0; i < NCH; i++) chModel[i] = (i == 0) ? CH0_RST : CHN_RST;
    for (int i = 0; i < NSU; i++) begin
      suModel[i] = SETUP_RST;
      filtModel[i] = FILT_RST;
      offModel[i] = OFFS_RST;
      gainModel[i] = GAIN_RST;
    end
    curChan = 2'h0;
    enMask = 4'h1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 checkRoute();
    // Reset values of every writable register kind
    readCheck("mode rst", ADDR_MODE, 24'(MODE_RST));
    readCheck("serial_interface_mode rst", ADDR_SERIAL_INTERFACE_MODE, 24'(SERIAL_INTERFACE_MODE_RST));
    for (int i = 0; i < 4; i++) begin
      readCheck("ch rst", ADDR_CH_BASE + 8'(i), 24'(chModel[i]));
      readCheck("setup rst", ADDR_SETUP_BASE + 8'(i), 24'(SETUP_RST));
      readCheck("filt rst", ADDR_FILT_BASE + 8'(i), 24'(FILT_RST));
      readCheck("offs rst", ADDR_OFFS_BASE + 8'(i), OFFS_RST);
      readCheck("gain rst", ADDR_GAIN_BASE + 8'(i), GAIN_RST);
    end
    $display("Test reset values done");
    // Interface mode fields, reserved bits and an unmapped place
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 16'hffff : rnd() & 16'hffff;
      busWrite(ADDR_SERIAL_INTERFACE_MODE, 24'(v));
      busWrite(8'h05, 24'hffffff);
      readCheck("serial_interface_mode", ADDR_SERIAL_INTERFACE_MODE, 24'(v & SERIAL_INTERFACE_MODE_MASK));
      check("shortWord", 24'(iface.shortWord), 24'(v[IF_WL_BIT]));
      check("crcMode", 24'(iface.crcMode), 24'(v[IF_CRC_LSB +: 2]));
      check("statusAppend", 24'(iface.statusAppend), 24'(v[IF_STAT_BIT]));
      check("continuous_read_enable", 24'(iface.continuous_read_enable), 24'(v[IF_CONTINUOUS_READ_ENABLE_BIT]));
      readCheck("unmapped", 8'h05, 24'h0);
      @(posedge clk);
      #1 check("rd stands", rdData_r, 24'h0);
    end
    $display("Test interface mode done");
    // Sequencing rounds with random channel and setup programming
    for (int r = 0; r < 10; r++) begin
      for (int i = 0; i < NSU; i++) begin
        suModel[i] = rnd() & SETUP_MASK;
        filtModel[i] = rnd() & FILT_MASK;
        busWrite(ADDR_SETUP_BASE + 8'(i), 24'(suModel[i]));
        busWrite(ADDR_FILT_BASE + 8'(i), 24'(filtModel[i]));
        // First round keeps correction registers unprogrammed
        if (r > 0) begin
          offModel[i] = rnd() & 24'hffffff;
          gainModel[i] = rnd() & 24'hffffff;
          busWrite(ADDR_OFFS_BASE + 8'(i), offModel[i]);
          busWrite(ADDR_GAIN_BASE + 8'(i), gainModel[i]);
        end
      end
      enMask = (r == 0) ? 4'hf : rnd() & 4'hf;
      if (enMask == 4'h0) enMask = 4'h8;
      common = 5'(rnd() % 5);
      for (int i = 0; i < NCH; i++) begin
        v = {enMask[i], 1'b0, 2'(rnd()), 2'h0, 5'(rnd() % 5), 5'(rnd() % 5)};
        if (r[0]) v[4:0] = common;
        chModel[i] = v & CH_MASK;
      end
      // Enable first and disable after, so the enabled set is never empty
      for (int p = 1; p >= 0; p--) begin
        for (int i = 0; i < NCH; i++) begin
          if (enMask[i] == p[0]) busWrite(ADDR_CH_BASE + 8'(i), 24'(chModel[i]));
        end
      end
      for (int i = 0; i < NCH; i++) begin
        readCheck("ch", ADDR_CH_BASE + 8'(i), 24'(chModel[i]));
      end
      for (int k = 0; k < 6; k++) advance(int'(rnd() % 2) + 1);
      // Stop with a non-continuous mode, then restart at lowest enabled
      v = (rnd() & MODE_MASK) | 16'h0010;
      busWrite(ADDR_MODE, 24'(v));
      repeat (3) @(posedge clk);
      #1 check("stopped", 24'(route_r.valid), 24'h0);
      check("refEnable", 24'(refEnable), 24'(v[MODE_REFEN_BIT]));
      check("singleCycle", 24'(singleCycle), 24'(v[MODE_SING_BIT]));
      check("delaySel", 24'(delaySel), 24'(v[MODE_DELAY_LSB +: 3]));
      check("convMode", 24'(convMode), 24'(v[MODE_CONV_LSB +: 3]));
      check("clockSel", 24'(clockSel), 24'(v[MODE_CLK_LSB +: 2]));
      busWrite(ADDR_MODE, 24'(MODE_RST));
      curChan = nextEn(2'h3, enMask);
      repeat (3) @(posedge clk);
      #1 checkRoute();
      readCheck("status", ADDR_STATUS, {16'h0000, enMask, 2'h1, curChan});
    end
    $display("Test sequencing done");
    tally_and_finish();
  end
endmodule // acs_config_bank_tb
